// File: rtl/cod_core.sv
// core datapath: registers, operand sequencing, memory master, register window
// Behaviour
// - sixteen-bit alu plus six sixteen-bit core registers
// - alu add, subtract, shift and logic finish in one cycle
// - alu carry lands in a separate one-bit carry flag
// - working register is source and destination of alu and memory moves
// - first and second pointers address memory and step up or down
// - limit register bounds the first pointer in loops
// - stack top rises two per push, falls two per pop
// - stack sits anywhere in memory, no hardware depth limit
// - fetch pointer supplies program fetch address
// - register indirect uses first pointer, or second on request
// - direct mode takes an 8 or 16-bit address from instruction
// - indirect mode reads word at 8-bit field, uses it as address
// - indexed mode adds 8 or 16-bit displacement to fetched word
// - immediate mode uses instruction field as operand, no memory read
// - auto-step reads at second pointer then steps it by 1 or 2
// - auto-step-skip reads at first pointer then steps it by 1 or 2
// - after stepping, compare first pointer with limit and raise skip
// - word accesses use even addresses; 64 kbyte byte-addressed space
// - skip on greater when stepping up, less when stepping down
`timescale 1ns/1ps
module cod_core #(
    parameter int DATA_W = 16
) (
    input  wire logic               clk_sys,
    input  wire logic               rst,
    input  wire logic               cmdValid,
    input  wire cod_pkg::cod_cmd_e  cmdKind,
    input  wire cod_pkg::cod_mode_e cmdMode,
    input  wire cod_pkg::cod_alu_e  cmdAluOp,
    input  wire logic               cmdWord,
    input  wire logic               cmdShort,
    input  wire logic               cmdDown,
    input  wire logic               cmdUseSecond,
    input  wire logic [15:0]        cmdField,
    input  wire logic [15:0]        cmdDisp,
    output logic                    busy,
    output logic                    done,
    output logic                    skipNext,
    output logic [15:0]             fetchData,
    output logic [15:0]             fetchPtr,
    output logic                    memReq,
    output logic                    memWe,
    output logic                    memWord,
    output logic [15:0]             memAddr,
    output logic [15:0]             memWdata,
    input  wire logic               memAck,
    input  wire logic [15:0]        memRdata,
    input  wire logic               regRd,
    input  wire logic               regWr,
    input  wire logic [15:0]        regAddr,
    input  wire logic [15:0]        regWdata,
    output logic [15:0]             regRdata
);
    if (DATA_W != cod_pkg::DW) begin : g_bad_width
        $error("cod_core supports only a 16-bit datapath");
    end

    typedef enum logic [2:0] {S_IDLE, S_ISSUE, S_PTR, S_OPER, S_EXEC} cod_state_e;

    cod_state_e         state_r;
    cod_pkg::cod_cmd_e  kind_r;
    cod_pkg::cod_mode_e mode_r;
    cod_pkg::cod_alu_e  aluOp_r;
    logic               word_r, short_r, down_r, useSecond_r;
    logic [15:0]        field_r, disp_r, ptrWord_r, operand_r;
    logic [15:0]        work_r, first_r, second_r, limit_r, stack_r, fetch_r;
    logic               carry_r;
    logic               busy_r, done_r, skip_r;
    logic [15:0]        fetchData_r, regRdata_r;
    logic               memReq_r, memWe_r, memWord_r;
    logic [15:0]        memAddr_r, memWdata_r;
    logic               accept, operAck, ptrAck, autoStep;
    logic [15:0]        wordAddr;

    cod_dp_if dp ();

    cod_alu  u_alu  (.dp(dp));
    cod_agen u_agen (.dp(dp));

    assign dp.aluOp     = aluOp_r;
    assign dp.aluA      = work_r;
    assign dp.aluB      = operand_r;
    assign dp.aluCin    = carry_r;
    assign dp.mode      = mode_r;
    assign dp.useSecond = useSecond_r;
    assign dp.isShort   = short_r;
    assign dp.down      = down_r;
    assign dp.word      = word_r;
    assign dp.field     = field_r;
    assign dp.disp      = disp_r;
    assign dp.ptrWord   = ptrAck ? memRdata : ptrWord_r;
    assign dp.first     = first_r;
    assign dp.second    = second_r;
    assign dp.limit     = limit_r;

    assign accept   = cmdValid && (state_r == S_IDLE);
    assign ptrAck   = (state_r == S_PTR) && memAck;
    assign operAck  = (state_r == S_OPER) && memAck;
    assign autoStep = operAck && (kind_r == cod_pkg::CMD_ALU || kind_r == cod_pkg::CMD_STORE)
                      && (mode_r == cod_pkg::MODE_AUTO || mode_r == cod_pkg::MODE_AUTOSKIP);
    // word accesses never leave an odd address on the bus
    assign wordAddr = word_r ? {dp.ea[15:1], 1'b0} : dp.ea;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            kind_r      <= cod_pkg::CMD_ALU;
            mode_r      <= cod_pkg::MODE_REGIND;
            aluOp_r     <= cod_pkg::ALU_PASS;
            word_r      <= 1'b0;
            short_r     <= 1'b0;
            down_r      <= 1'b0;
            useSecond_r <= 1'b0;
            field_r     <= cod_pkg::RST_VAL;
            disp_r      <= cod_pkg::RST_VAL;
        end else if (accept) begin
            kind_r      <= cmdKind;
            mode_r      <= cmdMode;
            aluOp_r     <= cmdAluOp;
            word_r      <= cmdWord;
            short_r     <= cmdShort;
            down_r      <= cmdDown;
            useSecond_r <= cmdUseSecond;
            field_r     <= cmdField;
            disp_r      <= cmdDisp;
        end
    end

    // sequencer and memory master
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_r    <= S_IDLE;
            memReq_r   <= 1'b0;
            memWe_r    <= 1'b0;
            memWord_r  <= 1'b0;
            memAddr_r  <= cod_pkg::RST_VAL;
            memWdata_r <= cod_pkg::RST_VAL;
        end else begin
            unique case (state_r)
                S_IDLE: if (accept) state_r <= S_ISSUE;
                S_ISSUE: begin
                    memReq_r   <= 1'b1;
                    memWe_r    <= 1'b0;
                    memWord_r  <= word_r;
                    memWdata_r <= work_r;
                    state_r    <= S_OPER;
                    unique case (kind_r)
                        cod_pkg::CMD_FETCH: begin
                            memWord_r <= 1'b0;
                            memAddr_r <= fetch_r;
                        end
                        cod_pkg::CMD_PUSH: begin
                            memWe_r   <= 1'b1;
                            memWord_r <= 1'b1;
                            memAddr_r <= {stack_r[15:1], 1'b0};
                        end
                        cod_pkg::CMD_POP: begin
                            memWord_r <= 1'b1;
                            memAddr_r <= {stack_r[15:1], 1'b0} - cod_pkg::STACK_STEP;
                        end
                        default: begin
                            memWe_r <= (kind_r == cod_pkg::CMD_STORE);
                            if (mode_r == cod_pkg::MODE_IMMED) begin
                                memReq_r <= 1'b0;
                                state_r  <= (kind_r == cod_pkg::CMD_ALU) ? S_EXEC : S_IDLE;
                            end else if (mode_r == cod_pkg::MODE_INDIRECT ||
                                         mode_r == cod_pkg::MODE_INDEXED) begin
                                memWe_r   <= 1'b0;
                                memWord_r <= 1'b1;
                                memAddr_r <= {dp.ptrAddr[15:1], 1'b0};
                                state_r   <= S_PTR;
                            end else begin
                                memAddr_r <= wordAddr;
                            end
                        end
                    endcase
                end
                S_PTR: if (memAck) begin
                    memWe_r   <= (kind_r == cod_pkg::CMD_STORE);
                    memWord_r <= word_r;
                    memAddr_r <= wordAddr;
                    state_r   <= S_OPER;
                end
                S_OPER: if (memAck) begin
                    memReq_r <= 1'b0;
                    memWe_r  <= 1'b0;
                    state_r  <= (kind_r == cod_pkg::CMD_ALU) ? S_EXEC : S_IDLE;
                end
                S_EXEC: state_r <= S_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ptrWord_r <= cod_pkg::RST_VAL;
            operand_r <= cod_pkg::RST_VAL;
        end else begin
            if (ptrAck) ptrWord_r <= memRdata;
            if (state_r == S_ISSUE)
                operand_r <= short_r ? {cod_pkg::HI_ZERO, field_r[7:0]} : field_r;
            else if (operAck)
                operand_r <= word_r ? memRdata : {cod_pkg::HI_ZERO, memRdata[7:0]};
        end
    end

    // working register and carry: a command write beats a window write
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            work_r  <= cod_pkg::RST_VAL;
            carry_r <= 1'b0;
        end else begin
            if (state_r == S_EXEC) work_r <= dp.aluY;
            else if (operAck && kind_r == cod_pkg::CMD_POP) work_r <= memRdata;
            else if (regWr && regAddr == cod_pkg::ADDR_WORK) work_r <= regWdata;
            if (state_r == S_EXEC) carry_r <= dp.aluCout;
            else if (regWr && regAddr == cod_pkg::ADDR_FLAGS)
                carry_r <= regWdata[cod_pkg::FLAG_CARRY];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            first_r  <= cod_pkg::RST_VAL;
            second_r <= cod_pkg::RST_VAL;
            limit_r  <= cod_pkg::RST_VAL;
        end else begin
            if (autoStep && mode_r == cod_pkg::MODE_AUTOSKIP) first_r <= dp.stepped;
            else if (regWr && regAddr == cod_pkg::ADDR_FIRST) first_r <= regWdata;
            if (autoStep && mode_r == cod_pkg::MODE_AUTO) second_r <= dp.stepped;
            else if (regWr && regAddr == cod_pkg::ADDR_SECOND) second_r <= regWdata;
            if (regWr && regAddr == cod_pkg::ADDR_LIMIT) limit_r <= regWdata;
        end
    end

    // stack grows upward by words, wrapping across the whole space
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            stack_r <= cod_pkg::RST_VAL;
        end else if (operAck && kind_r == cod_pkg::CMD_PUSH) begin
            stack_r <= stack_r + cod_pkg::STACK_STEP;
        end else if (operAck && kind_r == cod_pkg::CMD_POP) begin
            stack_r <= stack_r - cod_pkg::STACK_STEP;
        end else if (regWr && regAddr == cod_pkg::ADDR_STACK) begin
            stack_r <= regWdata;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            fetch_r     <= cod_pkg::RST_VAL;
            fetchData_r <= cod_pkg::RST_VAL;
        end else if (operAck && kind_r == cod_pkg::CMD_FETCH) begin
            fetch_r     <= fetch_r + cod_pkg::FETCH_STEP;
            fetchData_r <= {cod_pkg::HI_ZERO, memRdata[7:0]};
        end else if (regWr && regAddr == cod_pkg::ADDR_FETCH) begin
            fetch_r <= regWdata;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            busy_r <= 1'b0;
            done_r <= 1'b0;
            skip_r <= 1'b0;
        end else begin
            busy_r <= (state_r != S_IDLE) ? !(state_r == S_EXEC ||
                      (state_r == S_OPER && memAck && kind_r != cod_pkg::CMD_ALU) ||
                      (state_r == S_ISSUE && mode_r == cod_pkg::MODE_IMMED &&
                       kind_r == cod_pkg::CMD_STORE)) : accept;
            done_r <= (state_r == S_EXEC) ||
                      (operAck && kind_r != cod_pkg::CMD_ALU) ||
                      (state_r == S_ISSUE && mode_r == cod_pkg::MODE_IMMED &&
                       kind_r == cod_pkg::CMD_STORE);
            skip_r <= autoStep && mode_r == cod_pkg::MODE_AUTOSKIP && dp.skip;
        end
    end

    // register window read, one cycle after the strobe; holes read zero
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            regRdata_r <= cod_pkg::RST_VAL;
        end else if (regRd) begin
            unique case (regAddr)
                cod_pkg::ADDR_FLAGS:  regRdata_r <= {15'h0000, carry_r};
                cod_pkg::ADDR_STACK:  regRdata_r <= stack_r;
                cod_pkg::ADDR_FETCH:  regRdata_r <= fetch_r;
                cod_pkg::ADDR_WORK:   regRdata_r <= work_r;
                cod_pkg::ADDR_LIMIT:  regRdata_r <= limit_r;
                cod_pkg::ADDR_FIRST:  regRdata_r <= first_r;
                cod_pkg::ADDR_SECOND: regRdata_r <= second_r;
                default:              regRdata_r <= cod_pkg::RST_VAL;
            endcase
        end
    end

    assign busy      = busy_r;
    assign done      = done_r;
    assign skipNext  = skip_r;
    assign fetchData = fetchData_r;
    assign fetchPtr  = fetch_r;
    assign memReq    = memReq_r;
    assign memWe     = memWe_r;
    assign memWord   = memWord_r;
    assign memAddr   = memAddr_r;
    assign memWdata  = memWdata_r;
    assign regRdata  = regRdata_r;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence pushAck_s; operAck && kind_r == cod_pkg::CMD_PUSH; endsequence
    sequence popAck_s;  operAck && kind_r == cod_pkg::CMD_POP;  endsequence
    sequence skipUp_s;  autoStep && mode_r == cod_pkg::MODE_AUTOSKIP && !down_r; endsequence

    a_word_even: assert property (memReq_r && memWord_r |-> !memAddr_r[0])
        else $error("word access at odd address");
    a_push_step: assert property (pushAck_s |=> stack_r == $past(stack_r) + 16'h0002)
        else $error("push did not raise stack top by two");
    a_pop_step: assert property (popAck_s |=> stack_r == $past(stack_r) - 16'h0002)
        else $error("pop did not lower stack top by two");
    a_fetch_addr: assert property ((state_r == S_ISSUE && kind_r == cod_pkg::CMD_FETCH)
        |=> memReq_r && memAddr_r == fetch_r)
        else $error("fetch address not the fetch pointer");
    a_auto_second: assert property ((autoStep && mode_r == cod_pkg::MODE_AUTO && word_r
        && !down_r) |=> second_r == $past(second_r) + 16'h0002)
        else $error("second pointer word step wrong");
    a_skip_up: assert property (skipUp_s |=> skip_r == (first_r > limit_r))
        else $error("upward skip compare wrong");
    a_immed_nomem: assert property ((state_r == S_ISSUE && mode_r == cod_pkg::MODE_IMMED)
        |=> !memReq_r ##1 !memReq_r)
        else $error("immediate operand touched memory");
    a_exec_once: assert property (state_r == S_EXEC |=> done_r && state_r == S_IDLE)
        else $error("alu step took more than one cycle");
    a_carry_sep: assert property (state_r == S_EXEC |=> carry_r == $past(dp.aluCout))
        else $error("carry flag not loaded from alu");
    a_regind_first: assert property ((state_r == S_ISSUE && mode_r == cod_pkg::MODE_REGIND
        && !useSecond_r && !word_r && kind_r == cod_pkg::CMD_ALU)
        |=> memAddr_r == first_r)
        else $error("register indirect not at first pointer");
endmodule : cod_core

// File: rtl/cod_pkg.sv
// shared constants and types of the core operand datapath
package cod_pkg;
    localparam int          DW          = 16;
    localparam logic [15:0] ADDR_FLAGS  = 16'h00c0;
    localparam logic [15:0] ADDR_STACK  = 16'h00c4;
    localparam logic [15:0] ADDR_FETCH  = 16'h00c6;
    localparam logic [15:0] ADDR_WORK   = 16'h00c8;
    localparam logic [15:0] ADDR_LIMIT  = 16'h00ca;
    localparam logic [15:0] ADDR_FIRST  = 16'h00cc;
    localparam logic [15:0] ADDR_SECOND = 16'h00ce;
    localparam int          FLAG_CARRY  = 0;
    localparam logic [15:0] RST_VAL     = 16'h0000;
    localparam logic [15:0] STEP_BYTE   = 16'h0001;
    localparam logic [15:0] STEP_WORD   = 16'h0002;
    localparam logic [15:0] STACK_STEP  = 16'h0002;
    localparam logic [15:0] FETCH_STEP  = 16'h0001;
    localparam logic [7:0]  HI_ZERO     = 8'h00;

    typedef enum logic [3:0] {
        ALU_ADD, ALU_ADC, ALU_SUBC, ALU_AND, ALU_OR, ALU_XOR, ALU_SHL, ALU_SHR, ALU_PASS
    } cod_alu_e;
    typedef enum logic [2:0] {
        MODE_REGIND, MODE_DIRECT, MODE_INDIRECT, MODE_INDEXED, MODE_IMMED, MODE_AUTO,
        MODE_AUTOSKIP
    } cod_mode_e;
    typedef enum logic [2:0] {CMD_ALU, CMD_STORE, CMD_PUSH, CMD_POP, CMD_FETCH} cod_cmd_e;
endpackage : cod_pkg

// File: rtl/cod_dp_if.sv
// signals between the core and its alu and address generator
`timescale 1ns/1ps
interface cod_dp_if;
    cod_pkg::cod_alu_e  aluOp;
    logic [15:0]        aluA;
    logic [15:0]        aluB;
    logic               aluCin;
    logic [15:0]        aluY;
    logic               aluCout;
    cod_pkg::cod_mode_e mode;
    logic               useSecond;
    logic               isShort;
    logic               down;
    logic               word;
    logic [15:0]        field;
    logic [15:0]        disp;
    logic [15:0]        ptrWord;
    logic [15:0]        first;
    logic [15:0]        second;
    logic [15:0]        limit;
    logic [15:0]        ptrAddr;
    logic [15:0]        ea;
    logic [15:0]        stepped;
    logic               skip;

    modport alu  (input aluOp, aluA, aluB, aluCin, output aluY, aluCout);
    modport agen (input mode, useSecond, isShort, down, word, field, disp, ptrWord, first,
                  second, limit, output ptrAddr, ea, stepped, skip);
    modport core (output aluOp, aluA, aluB, aluCin, mode, useSecond, isShort, down, word,
                  field, disp, ptrWord, first, second, limit,
                  input aluY, aluCout, ptrAddr, ea, stepped, skip);
endinterface : cod_dp_if

// File: rtl/cod_alu.sv
// 16-bit alu, single pass, carry out beside the result
`timescale 1ns/1ps
module cod_alu (
    cod_dp_if.alu dp
);
    logic [16:0] sum;

    always_comb begin
        sum        = 17'h00000;
        dp.aluY    = 16'h0000;
        dp.aluCout = dp.aluCin;
        unique case (dp.aluOp)
            cod_pkg::ALU_ADD: begin
                sum = {1'b0, dp.aluA} + {1'b0, dp.aluB};
                {dp.aluCout, dp.aluY} = sum;
            end
            cod_pkg::ALU_ADC: begin
                sum = {1'b0, dp.aluA} + {1'b0, dp.aluB} + {16'h0000, dp.aluCin};
                {dp.aluCout, dp.aluY} = sum;
            end
            cod_pkg::ALU_SUBC: begin
                // carry in acts as not-borrow
                sum = {1'b0, dp.aluA} + {1'b0, ~dp.aluB} + {16'h0000, dp.aluCin};
                {dp.aluCout, dp.aluY} = sum;
            end
            cod_pkg::ALU_AND:  dp.aluY = dp.aluA & dp.aluB;
            cod_pkg::ALU_OR:   dp.aluY = dp.aluA | dp.aluB;
            cod_pkg::ALU_XOR:  dp.aluY = dp.aluA ^ dp.aluB;
            cod_pkg::ALU_SHL:  {dp.aluCout, dp.aluY} = {dp.aluA, 1'b0};
            cod_pkg::ALU_SHR:  {dp.aluY, dp.aluCout} = {1'b0, dp.aluA};
            cod_pkg::ALU_PASS: dp.aluY = dp.aluB;
            default:           dp.aluY = 16'h0000;
        endcase
    end
endmodule : cod_alu

// File: rtl/cod_agen.sv
// operand address, pointer step and limit compare
`timescale 1ns/1ps
module cod_agen (
    cod_dp_if.agen dp
);
    logic [15:0] fieldX;
    logic [15:0] dispX;
    logic [15:0] base;
    logic [15:0] stepAmt;

    always_comb begin
        fieldX     = dp.isShort ? {cod_pkg::HI_ZERO, dp.field[7:0]} : dp.field;
        dispX      = dp.isShort ? {cod_pkg::HI_ZERO, dp.disp[7:0]} : dp.disp;
        dp.ptrAddr = {cod_pkg::HI_ZERO, dp.field[7:0]};
        unique case (dp.mode)
            cod_pkg::MODE_REGIND:   dp.ea = dp.useSecond ? dp.second : dp.first;
            cod_pkg::MODE_DIRECT:   dp.ea = fieldX;
            cod_pkg::MODE_INDIRECT: dp.ea = dp.ptrWord;
            cod_pkg::MODE_INDEXED:  dp.ea = dp.ptrWord + dispX;
            cod_pkg::MODE_AUTO:     dp.ea = dp.second;
            cod_pkg::MODE_AUTOSKIP: dp.ea = dp.first;
            default:                dp.ea = fieldX;
        endcase
        base       = (dp.mode == cod_pkg::MODE_AUTO) ? dp.second : dp.first;
        stepAmt    = dp.word ? cod_pkg::STEP_WORD : cod_pkg::STEP_BYTE;
        // sums wrap in 16 bits, no error
        dp.stepped = dp.down ? base - stepAmt : base + stepAmt;
        dp.skip    = dp.down ? (dp.stepped < dp.limit) : (dp.stepped > dp.limit);
    end
endmodule : cod_agen

// File: verification/cod_mem_model.sv
// byte memory on the far side of the core bus, fast or slow to answer
`timescale 1ns/1ps
module cod_mem_model (
    input  wire logic        clk_sys,
    input  wire logic        slow,
    input  wire logic        memReq,
    input  wire logic        memWe,
    input  wire logic        memWord,
    input  wire logic [15:0] memAddr,
    input  wire logic [15:0] memWdata,
    output logic             memAck,
    output logic [15:0]      memRdata
);
    logic [7:0]  mem [0:65535];
    logic [15:0] ev;
    int          cnt = 0;
    assign ev = memAddr & 16'hfffe;
    initial {memAck, memRdata} = 17'h0;
    always @(posedge clk_sys) begin
        memAck   <= 1'b0;
        memRdata <= ~memRdata;  // data off the ack cycle must never look valid
        cnt      <= memReq && !memAck ? cnt + 1 : 0;
        if (memReq && !memAck && cnt >= (slow ? 3 : 0)) begin
            memAck <= 1'b1;
            memRdata <= memWord ? {mem[ev + 16'h1], mem[ev]} : {~mem[memAddr], mem[memAddr]};
            if (memWe && memWord) {mem[ev + 16'h1], mem[ev]} <= memWdata;
            else if (memWe) mem[memAddr] <= memWdata[7:0];
        end
    end
endmodule : cod_mem_model

// File: verification/cpu_core_operand_datapath_test.sv
// self-checking bench of the core operand datapath
`timescale 1ns/1ps
module cpu_core_operand_datapath_test;
    logic clk_sys = 0, rst = 1, cmdValid = 0, regRd = 0, regWr = 0, slow = 0, sk;
    logic cmdWord = 0, cmdShort = 0, cmdDown = 0, cmdUseSecond = 0;
    logic busy, done, skipNext, memReq, memWe, memWord, memAck;
    logic [15:0] cmdField = 0, cmdDisp = 0, regAddr = 0, regWdata = 0, fetchData, fetchPtr;
    logic [15:0] memAddr, memWdata, memRdata, regRdata;
    cod_pkg::cod_cmd_e  cmdKind = cod_pkg::CMD_ALU;
    cod_pkg::cod_mode_e cmdMode = cod_pkg::MODE_IMMED;
    cod_pkg::cod_alu_e  cmdAluOp = cod_pkg::ALU_PASS;
    int n_mismatch = 0, cmp_count = 0, seed = 12396, r[8], i, j, a, e, v, st;
    always #2.5 clk_sys = ~clk_sys;
    cod_core u_dut (.clk_sys, .rst, .cmdValid, .cmdKind, .cmdMode, .cmdAluOp, .cmdWord,
        .cmdShort, .cmdDown, .cmdUseSecond, .cmdField, .cmdDisp, .busy, .done, .skipNext,
        .fetchData, .fetchPtr, .memReq, .memWe, .memWord, .memAddr, .memWdata, .memAck,
        .memRdata, .regRd, .regWr, .regAddr, .regWdata, .regRdata);
    cod_mem_model u_mem (.clk_sys, .slow, .memReq, .memWe, .memWord, .memAddr, .memWdata,
        .memAck, .memRdata);
    function automatic int mv(input int ad, input int wd);
        ad &= 'hffff;
        return wd ? {u_mem.mem[ad | 1], u_mem.mem[ad & 'hfffe]} : u_mem.mem[ad];
    endfunction : mv
    function automatic void alu(input int op, input int b);
        int y;
        case (op)
            0: y = r[4] + b;
            1: y = r[4] + b + r[0];
            2: y = r[4] + (b ^ 'hffff) + r[0];
            3: y = (r[4] & b) | r[0] << 16;
            4: y = r[4] | b | r[0] << 16;
            5: y = (r[4] ^ b) | r[0] << 16;
            6: y = r[4] << 1;
            7: y = r[4] >> 1 | (r[4] & 1) << 16;
            default: y = b | r[0] << 16;
        endcase
        r[4] = y & 'hffff;
        r[0] = y >> 16 & 1;
    endfunction : alu
    task automatic end_sim;
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic rd(input logic [15:0] ad, input logic [15:0] exp);
        {regAddr, regRd} = {ad, 1'b1};
        @(posedge clk_sys);
        #1 regRd = 0;
        chk(regRdata, exp);
        @(posedge clk_sys);
        #1;
    endtask : rd
    task automatic wr(input logic [15:0] ad, input int d);
        {regAddr, regWdata, regWr} = {ad, 16'(d), 1'b1};
        @(posedge clk_sys);
        #1 regWr = 0;
        @(posedge clk_sys);
        #1;
    endtask : wr
    task automatic ck;
        for (int q = 0; q < 8; q++) rd(16'h00c0 + 16'(2 * q), 16'(r[q]));
    endtask : ck
    task automatic run(input int kd, md, op, wd, sh, dn, us, f, d);
        int t;
        cmdKind = cod_pkg::cod_cmd_e'(kd);
        cmdMode = cod_pkg::cod_mode_e'(md);
        cmdAluOp = cod_pkg::cod_alu_e'(op);
        {cmdWord, cmdShort, cmdDown, cmdUseSecond} = {wd[0], sh[0], dn[0], us[0]};
        {cmdField, cmdDisp, slow} = {16'(f), 16'(d), 1'($random(seed))};
        {cmdValid, sk, t} = {1'b1, 1'b0, 32'h0};
        @(posedge clk_sys);
        #1 cmdValid = 0;
        chk(16'(busy), 16'h1);
        while (done !== 1'b1 && t < 60) begin
            @(posedge clk_sys);
            #1 t++;
            if (skipNext === 1'b1) sk = 1;
        end
        if (t == 60) chk(16'h0, 16'h1);
        chk(16'(busy), 16'h0);
        @(posedge clk_sys);
        #1;
    endtask : run
    initial begin
        for (int q = 0; q < 65536; q++) u_mem.mem[q] = 8'($random(seed));
        repeat (4) @(posedge clk_sys);
        #1 rst = 0;
        for (i = 0; i < 8; i++) begin
            rd(16'h00c0 + 16'(2 * i), 16'h0);
            v = $random(seed) & (i == 2 ? 'hfffe : 'hffff);
            wr(16'h00c0 + 16'(2 * i), v);
            r[i] = i == 0 ? v & 1 : i == 1 ? 0 : v;
        end
        for (i = 0; i < 9; i++) begin
            v = $random(seed) & 'hffff;
            run(0, 4, i, 1, i & 1, 0, 0, v, 0);
            alu(i, i & 1 ? v & 'hff : v);
            ck;
        end
        for (j = 0; j < 42; j++) begin
            {i, v, a} = {32'(j % 7), $random(seed) & ~32'h0080_0000, $random(seed) & 'hffff};
            if (i == 4) continue;
            st = v[0] ? 2 : 1;
            case (i)
                0: e = v[3] ? r[7] : r[6];
                1: e = v[1] ? v[23:16] : v[31:16];
                2: e = mv(v[23:16], 1);
                3: e = mv(v[23:16], 1) + (v[1] ? a & 'hff : a);
                5: e = r[7];
                default: e = r[6];
            endcase
            run(0, i, j % 9, v[0], v[1], v[2], v[3], v[31:16], a);
            alu(j % 9, mv(e, v[0]));
            if (i == 5) r[7] = (r[7] + (v[2] ? -st : st)) & 'hffff;
            if (i == 6) r[6] = (r[6] + (v[2] ? -st : st)) & 'hffff;
            chk(16'(sk), 16'(i == 6 && (v[2] ? r[6] < r[5] : r[6] > r[5])));
            ck;
        end
        wr(16'h00ce, 'hffff);
        run(0, 5, 8, 0, 0, 0, 0, 0, 0);
        alu(8, mv('hffff, 0));
        r[7] = 0;
        ck;
        run(2, 0, 8, 1, 0, 0, 0, 0, 0);
        chk(16'(mv(r[2], 1)), 16'(r[4]));
        r[2] = (r[2] + 2) & 'hffff;
        run(0, 4, 8, 1, 0, 0, 0, 'h1234, 0);
        run(3, 0, 8, 1, 0, 0, 0, 0, 0);
        r[2] = (r[2] - 2) & 'hffff;
        ck;
        run(1, 1, 8, 1, 0, 0, 0, 'h0400, 0);
        chk(16'(mv('h400, 1)), 16'(r[4]));
        run(1, 4, 8, 1, 0, 0, 0, 'h0400, 0);
        ck;
        for (i = 0; i < 3; i++) begin
            v = r[3];
            run(4, 0, 8, 0, 0, 0, 0, 0, 0);
            r[3] = (r[3] + 1) & 'hffff;
            chk(fetchData, 16'(mv(v, 0)));
            chk(fetchPtr, 16'(r[3]));
        end
        end_sim;
    end
    // about 1200 cycles expected, cut off at sixteen times that
    initial begin
        #100000;
        n_mismatch++;
        end_sim;
    end
endmodule : cpu_core_operand_datapath_test
